// ### core/adc_touch_cfg.svh
// Summary of operation
// - done flag at bit 15, read only
// - bit 14 gates the conversion divider
// - conversion clock is bus clock over N+1
// - bit 3 picks 10 or 12 bits
// - bit 2 holds converter in standby
// - start-by-read starts conversion on data read
// - start bit starts, self clears, read mode ignores
// - touch bit 8 picks stylus down or up
// - bit 7 grounds y-minus pad
// - bit 6 low powers y-plus pad
// - bit 5 grounds x-minus pad
// - bit 4 low powers x-plus pad
// - bit 3 low enables x-plus pull-up
// - bit 2 selects automatic x then y
// - bits 1:0 pick manual measurement mode
// - conversion start delayed by bus clock count
// - stylus down debounced on crystal clock count
// - auto: x to first, y to second, irq
// - standby halts, results kept
// - conversion takes five conversion clock cycles
`ifndef ADC_TOUCH_CFG_SVH
`define ADC_TOUCH_CFG_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_CONV_CTRL 32'h58000000
`define OFS_TOUCH_CTRL 32'h58000004
`define OFS_START_DELAY 32'h58000008
`define OFS_RESULT_FIRST 32'h5800000c
`define OFS_RESULT_SECOND 32'h58000010

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CC_DONE_BIT 15
`define CC_DIVEN_BIT 14
`define CC_DIV_HI 13
`define CC_DIV_LO 6
`define CC_RES_BIT 3
`define CC_STBY_BIT 2
`define CC_RDST_BIT 1
`define CC_START_BIT 0
`define TP_EDGE_BIT 8
`define TP_YM_BIT 7
`define TP_YP_BIT 6
`define TP_XM_BIT 5
`define TP_XP_BIT 4
`define TP_PU_BIT 3
`define TP_AUTO_BIT 2
`define TP_MS_HI 1
`define TP_MS_LO 0
`define RD_UPDN_BIT 15
`define RD_AUTO_BIT 14
`define RD_MS_HI 13
`define RD_MS_LO 12
`define CC_RESET 16'h3fc4
`define TP_RESET 9'h058
`define DLY_RESET 16'h00ff

// ----------------------------------------
// timing and channels
// ----------------------------------------
`define CONV_CYCLES 3'h5
`define CH_X_MEAS 4'h7
`define CH_Y_MEAS 4'h9

`endif

// ### core/adc_touch_pkg.sv
package adc_touch_pkg;

    // manual measurement field codes
    typedef enum logic [1:0] {
        MS_NOP = 2'h0,
        MS_X = 2'h1,
        MS_Y = 2'h2,
        MS_WAIT = 2'h3
    } measure_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DELAY = 3'h2,
        ST_CONV = 3'h4
    } seq_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
        logic level;
    } div_state_t;

    typedef struct packed {
        logic [2:0] xs;
        logic xlvl;
        logic busy;
        logic [15:0] cnt;
        logic irq;
    } deb_state_t;

    typedef struct packed {
        logic div_en;
        logic [7:0] div_val;
        logic res12;
        logic standby;
        logic rd_start;
        logic start;
        logic done;
        logic [8:0] touch;
        logic [15:0] delay;
        seq_state_t st;
        logic [15:0] dcnt;
        logic [2:0] tcnt;
        logic phase_y;
        logic [11:0] res0;
        logic [11:0] res1;
        logic [31:0] prdata;
        logic [2:0] ss;
        logic stylus;
        logic soc;
        logic conv_irq;
        logic edge_ev;
    } ctl_state_t;

endpackage

// ### core/conv_clock_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_touch_cfg.svh"

module conv_clock_divider (
    input wire logic clk_in, // bus clock
    input wire logic nrst_in, // async reset, active low
    input wire logic enable_in, // divider enable
    input wire logic [7:0] value_in, // division value n
    output logic tick_out, // one pulse per n+1 cycles
    output logic level_out // conversion clock level
);

    adc_touch_pkg::div_state_t s_r;
    adc_touch_pkg::div_state_t s_nxt;

    // count 0..n; disabled divider holds still so nothing converts
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!enable_in) begin
            s_nxt.cnt = 8'h00;
            s_nxt.level = 1'b0;
        end else if (s_r.cnt >= value_in) begin
            s_nxt.cnt = 8'h00;
            s_nxt.tick = 1'b1;
            s_nxt.level = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (s_r.cnt == {1'b0, value_in[7:1]}) begin
                s_nxt.level = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.tick;
    assign level_out = s_r.level;

endmodule // conv_clock_divider
`default_nettype wire

// ### core/stylus_debounce.sv
`timescale 1ns/100ps
`default_nettype none

module stylus_debounce (
    input wire logic clk_in, // bus clock
    input wire logic nrst_in, // async reset, active low
    input wire logic xtal_in, // crystal clock pin, sampled
    input wire logic arm_in, // waiting-for-touch mode
    input wire logic trig_in, // stylus event, one cycle
    input wire logic [15:0] delay_in, // edges to count
    output logic irq_out // touch event pulse
);

    adc_touch_pkg::deb_state_t s_r;
    adc_touch_pkg::deb_state_t s_nxt;
    logic xedge;

    // crystal is slow and foreign: three stages, count once two agree
    always_comb begin
        s_nxt = s_r;
        s_nxt.irq = 1'b0;
        s_nxt.xs = {s_r.xs[1:0], xtal_in};
        xedge = 1'b0;
        if (s_r.xs[1] == s_r.xs[2]) begin
            s_nxt.xlvl = s_r.xs[2];
            xedge = s_r.xs[2] & ~s_r.xlvl;
        end
        if (!arm_in) begin
            s_nxt.busy = 1'b0;
        end else if (trig_in && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = delay_in;
        end else if (s_r.busy && xedge) begin
            if (s_r.cnt <= 16'h0001) begin
                s_nxt.busy = 1'b0;
                s_nxt.irq = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign irq_out = s_r.irq;

endmodule // stylus_debounce
`default_nettype wire

// ### core/adc_touch_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_touch_cfg.svh"

module adc_touch_control_regs (
    input wire logic CLK_IN, // bus clock, 20 MHz
    input wire logic NRST_IN, // async reset, active low
    input wire logic PSEL_IN, // apb select
    input wire logic PENABLE_IN, // apb enable
    input wire logic PWRITE_IN, // apb direction
    input wire logic [31:0] PADDR_IN, // apb byte address
    input wire logic [31:0] PWDATA_IN, // apb write data
    output logic [31:0] PRDATA_OUT, // apb read data
    output logic PREADY_OUT, // apb ready
    output logic PSLVERR_OUT, // apb error, unmapped
    input wire logic [11:0] ADC_DATA_IN, // converter raw result
    input wire logic [3:0] NORMAL_CHAN_IN, // channel for normal mode
    input wire logic STYLUS_DOWN_IN, // panel comparator, high pressed
    input wire logic XTAL_IN, // external crystal clock pin
    output logic CONV_CLK_OUT, // conversion clock
    output logic CONV_START_OUT, // start of conversion pulse
    output logic CONV_BUSY_OUT, // conversion sequence running
    output logic RES12_OUT, // 12-bit resolution select
    output logic STANDBY_OUT, // analog standby
    output logic [3:0] CHANNEL_OUT, // analog input select
    output logic YM_GROUND_OUT, // y-minus to ground
    output logic YP_SUPPLY_N_OUT, // y-plus to supply, low on
    output logic XM_GROUND_OUT, // x-minus to ground
    output logic XP_SUPPLY_N_OUT, // x-plus to supply, low on
    output logic XP_PULLUP_N_OUT, // x-plus pull-up, low on
    output logic CONV_IRQ_OUT, // conversion done pulse
    output logic TOUCH_IRQ_OUT // debounced touch pulse
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------

    // one-hot select: ctrl, touch, delay, first, second
    function automatic logic [4:0] reg_sel(input logic [31:0] addr);
        logic [4:0] sel;
        sel = 5'h00;
        case (addr)
            `OFS_CONV_CTRL: sel = 5'h01;
            `OFS_TOUCH_CTRL: sel = 5'h02;
            `OFS_START_DELAY: sel = 5'h04;
            `OFS_RESULT_FIRST: sel = 5'h08;
            `OFS_RESULT_SECOND: sel = 5'h10;
            default: sel = 5'h00;
        endcase
        return sel;
    endfunction

    // result word with mode mirrors above the data
    function automatic logic [31:0] result_word(input logic [11:0] data, input logic updn,
                                                input logic [8:0] tp);
        logic [31:0] w;
        w = 32'h00000000;
        w[11:0] = data;
        w[`RD_UPDN_BIT] = updn;
        w[`RD_AUTO_BIT] = tp[`TP_AUTO_BIT];
        w[`RD_MS_HI:`RD_MS_LO] = tp[`TP_MS_HI:`TP_MS_LO];
        return w;
    endfunction

    // ----------------------------------------
    // state and submodules
    // ----------------------------------------

    adc_touch_pkg::ctl_state_t s_r;
    adc_touch_pkg::ctl_state_t s_nxt;
    adc_touch_pkg::measure_t mode;
    logic conv_tick;
    logic conv_lvl;
    logic touch_irq;
    logic setup_ph;
    logic access_ph;
    logic [4:0] sel;
    logic wr_ctrl;
    logic wr_touch;
    logic wr_delay;
    logic rd_result;
    logic go;
    logic auto_on;
    logic [11:0] sample;

    conv_clock_divider u_div (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .enable_in(s_r.div_en),
        .value_in(s_r.div_val),
        .tick_out(conv_tick),
        .level_out(conv_lvl)
    );

    stylus_debounce u_deb (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .xtal_in(XTAL_IN),
        .arm_in(mode == adc_touch_pkg::MS_WAIT),
        .trig_in(s_r.edge_ev),
        .delay_in(s_r.delay),
        .irq_out(touch_irq)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------

    // zero wait states: read data is latched in the setup cycle
    assign setup_ph = PSEL_IN & ~PENABLE_IN;
    assign access_ph = PSEL_IN & PENABLE_IN;
    assign sel = reg_sel(PADDR_IN);
    assign wr_ctrl = access_ph & PWRITE_IN & sel[0];
    assign wr_touch = access_ph & PWRITE_IN & sel[1];
    assign wr_delay = access_ph & PWRITE_IN & sel[2];
    assign rd_result = access_ph & ~PWRITE_IN & (sel[3] | sel[4]);
    assign mode = adc_touch_pkg::measure_t'(s_r.touch[`TP_MS_HI:`TP_MS_LO]);
    assign auto_on = s_r.touch[`TP_AUTO_BIT];

    // start source: read-start mode masks the start bit
    always_comb begin
        if (s_r.rd_start) begin
            go = rd_result;
        end else begin
            go = s_r.start;
        end
    end

    // 10-bit mode keeps the top ten bits of the sample
    assign sample = s_r.res12 ? ADC_DATA_IN : {2'h0, ADC_DATA_IN[11:2]};

    // ----------------------------------------
    // next state
    // ----------------------------------------

    always_comb begin
        s_nxt = s_r;
        s_nxt.soc = 1'b0;
        s_nxt.conv_irq = 1'b0;
        s_nxt.edge_ev = 1'b0;

        // stylus pin: three stages, change taken when two agree
        s_nxt.ss = {s_r.ss[1:0], STYLUS_DOWN_IN};
        if (s_r.ss[1] == s_r.ss[2]) begin
            s_nxt.stylus = s_r.ss[2];
            if (s_r.ss[2] != s_r.stylus) begin
                // edge select: 0 waits for press, 1 for release
                s_nxt.edge_ev = s_r.touch[`TP_EDGE_BIT] ? ~s_r.ss[2] : s_r.ss[2];
            end
        end

        // register writes; done flag is not writable
        if (wr_ctrl) begin
            s_nxt.div_en = PWDATA_IN[`CC_DIVEN_BIT];
            s_nxt.div_val = PWDATA_IN[`CC_DIV_HI:`CC_DIV_LO];
            s_nxt.res12 = PWDATA_IN[`CC_RES_BIT];
            s_nxt.standby = PWDATA_IN[`CC_STBY_BIT];
            s_nxt.rd_start = PWDATA_IN[`CC_RDST_BIT];
            s_nxt.start = PWDATA_IN[`CC_START_BIT];
        end
        if (wr_touch) begin
            s_nxt.touch = PWDATA_IN[8:0];
        end
        if (wr_delay) begin
            s_nxt.delay = PWDATA_IN[15:0];
        end

        // read data captured in setup, held through access
        if (setup_ph) begin
            s_nxt.prdata = 32'h00000000;
            case (sel)
                5'h01: begin
                    s_nxt.prdata[`CC_DONE_BIT] = s_r.done;
                    s_nxt.prdata[`CC_DIVEN_BIT] = s_r.div_en;
                    s_nxt.prdata[`CC_DIV_HI:`CC_DIV_LO] = s_r.div_val;
                    s_nxt.prdata[`CC_RES_BIT] = s_r.res12;
                    s_nxt.prdata[`CC_STBY_BIT] = s_r.standby;
                    s_nxt.prdata[`CC_RDST_BIT] = s_r.rd_start;
                    s_nxt.prdata[`CC_START_BIT] = s_r.start;
                end
                5'h02: s_nxt.prdata[8:0] = s_r.touch;
                5'h04: s_nxt.prdata[15:0] = s_r.delay;
                5'h08: s_nxt.prdata = result_word(s_r.res0, ~s_r.stylus, s_r.touch);
                5'h10: s_nxt.prdata = result_word(s_r.res1, ~s_r.stylus, s_r.touch);
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end

        // sequencer
        if (s_r.standby) begin
            // halted; results stay as they were
            s_nxt.st = adc_touch_pkg::ST_IDLE;
            s_nxt.phase_y = 1'b0;
        end else begin
            case (s_r.st)
                adc_touch_pkg::ST_IDLE: begin
                    if (go && mode != adc_touch_pkg::MS_WAIT) begin
                        s_nxt.st = adc_touch_pkg::ST_DELAY;
                        s_nxt.dcnt = s_r.delay;
                        s_nxt.done = 1'b0;
                        s_nxt.phase_y = 1'b0;
                        s_nxt.start = 1'b0;
                    end
                end
                adc_touch_pkg::ST_DELAY: begin
                    // a zero delay behaves like one cycle
                    if (s_r.dcnt <= 16'h0001) begin
                        s_nxt.st = adc_touch_pkg::ST_CONV;
                        s_nxt.tcnt = 3'h0;
                        s_nxt.soc = 1'b1;
                    end else begin
                        s_nxt.dcnt = s_r.dcnt - 16'h0001;
                    end
                end
                adc_touch_pkg::ST_CONV: begin
                    if (conv_tick) begin
                        if (s_r.tcnt == `CONV_CYCLES - 3'h1) begin
                            if (s_r.phase_y || (!auto_on && mode == adc_touch_pkg::MS_Y)) begin
                                s_nxt.res1 = sample;
                            end else begin
                                s_nxt.res0 = sample;
                            end
                            if (auto_on && !s_r.phase_y) begin
                                // auto: move on to y by itself
                                s_nxt.phase_y = 1'b1;
                                s_nxt.st = adc_touch_pkg::ST_DELAY;
                                s_nxt.dcnt = s_r.delay;
                            end else begin
                                s_nxt.st = adc_touch_pkg::ST_IDLE;
                                s_nxt.phase_y = 1'b0;
                                s_nxt.done = 1'b1;
                                s_nxt.conv_irq = 1'b1;
                            end
                        end else begin
                            s_nxt.tcnt = s_r.tcnt + 3'h1;
                        end
                    end
                end
                default: s_nxt.st = adc_touch_pkg::ST_IDLE;
            endcase
        end

        // a start write in the same cycle as the clear still counts
        if (wr_ctrl && PWDATA_IN[`CC_START_BIT]) begin
            s_nxt.start = 1'b1;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------

    // reset values come straight from the register reset words
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            s_r <= '0;
            s_r.div_en <= 1'(`CC_RESET >> `CC_DIVEN_BIT);
            s_r.div_val <= 8'(`CC_RESET >> `CC_DIV_LO);
            s_r.res12 <= 1'(`CC_RESET >> `CC_RES_BIT);
            s_r.standby <= 1'(`CC_RESET >> `CC_STBY_BIT);
            s_r.rd_start <= 1'(`CC_RESET >> `CC_RDST_BIT);
            s_r.start <= 1'(`CC_RESET >> `CC_START_BIT);
            s_r.done <= 1'b0;
            s_r.touch <= `TP_RESET;
            s_r.delay <= `DLY_RESET;
            s_r.st <= adc_touch_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    assign PRDATA_OUT = s_r.prdata;
    assign PREADY_OUT = access_ph;
    assign PSLVERR_OUT = access_ph & (sel == 5'h00);
    assign CONV_CLK_OUT = conv_lvl;
    assign CONV_START_OUT = s_r.soc;
    assign CONV_BUSY_OUT = s_r.st != adc_touch_pkg::ST_IDLE;
    assign RES12_OUT = s_r.res12;
    assign STANDBY_OUT = s_r.standby;
    assign CONV_IRQ_OUT = s_r.conv_irq;
    assign TOUCH_IRQ_OUT = touch_irq;
    assign XP_PULLUP_N_OUT = s_r.touch[`TP_PU_BIT];

    // auto sequence drives the pads itself; otherwise software bits
    always_comb begin
        YM_GROUND_OUT = s_r.touch[`TP_YM_BIT];
        YP_SUPPLY_N_OUT = s_r.touch[`TP_YP_BIT];
        XM_GROUND_OUT = s_r.touch[`TP_XM_BIT];
        XP_SUPPLY_N_OUT = s_r.touch[`TP_XP_BIT];
        CHANNEL_OUT = NORMAL_CHAN_IN;
        if (auto_on && CONV_BUSY_OUT) begin
            YM_GROUND_OUT = s_r.phase_y;
            YP_SUPPLY_N_OUT = ~s_r.phase_y;
            XM_GROUND_OUT = ~s_r.phase_y;
            XP_SUPPLY_N_OUT = s_r.phase_y;
            CHANNEL_OUT = s_r.phase_y ? `CH_Y_MEAS : `CH_X_MEAS;
        end else if (mode == adc_touch_pkg::MS_X) begin
            CHANNEL_OUT = `CH_X_MEAS;
        end else if (mode == adc_touch_pkg::MS_Y) begin
            CHANNEL_OUT = `CH_Y_MEAS;
        end
    end

endmodule // adc_touch_control_regs
`default_nettype wire

// ### dv/adc_touch_control_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module adc_touch_control_regs_chk (
    input wire logic CLK_IN, // clock
    input wire logic NRST_IN, // reset, low
    input wire logic CONV_START_OUT, // start pulse
    input wire logic CONV_BUSY_OUT, // busy
    input wire logic STANDBY_OUT, // standby
    input wire logic CONV_IRQ_OUT, // done pulse
    input wire logic TOUCH_IRQ_OUT, // touch pulse
    input wire logic YP_SUPPLY_N_OUT, // y-plus switch
    input wire logic XP_SUPPLY_N_OUT, // x-plus switch
    input wire logic XP_PULLUP_N_OUT // pull-up
);
    // ----
    // sequencer and pad checks
    // ----
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // five slow ticks keep the sequencer busy far past eight cycles
    sequence conv_run;
        CONV_BUSY_OUT [*8];
    endsequence
    // supply and pull-up switches off, converter parked
    sequence pads_off;
        STANDBY_OUT && YP_SUPPLY_N_OUT && XP_SUPPLY_N_OUT && XP_PULLUP_N_OUT;
    endsequence
    AST_START_PULSE: assert property (CONV_START_OUT |=> !CONV_START_OUT)
        else $error("start pulse too long");
    AST_IRQ_PULSE: assert property (CONV_IRQ_OUT |=> !CONV_IRQ_OUT)
        else $error("done pulse too long");
    AST_TOUCH_PULSE: assert property (TOUCH_IRQ_OUT |=> !TOUCH_IRQ_OUT)
        else $error("touch pulse too long");
    AST_STBY_HALT: assert property (STANDBY_OUT |-> !CONV_START_OUT)
        else $error("start in standby");
    AST_DELAY_FIRST: assert property ($rose(CONV_BUSY_OUT) |-> !CONV_START_OUT)
        else $error("start without delay");
    AST_RUN_ACTIVE: assert property ($rose(CONV_BUSY_OUT) |-> !STANDBY_OUT)
        else $error("sequence left idle in standby");
    AST_CONV_HOLD: assert property (CONV_START_OUT |=> conv_run)
        else $error("conversion ended too soon");
    AST_RESET_PADS: assert property ($rose(NRST_IN) |-> pads_off)
        else $error("wrong state after reset");
endmodule // adc_touch_control_regs_chk
bind adc_touch_control_regs adc_touch_control_regs_chk chk (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
    .CONV_START_OUT(CONV_START_OUT), .CONV_BUSY_OUT(CONV_BUSY_OUT), .STANDBY_OUT(STANDBY_OUT),
    .CONV_IRQ_OUT(CONV_IRQ_OUT), .TOUCH_IRQ_OUT(TOUCH_IRQ_OUT), .YP_SUPPLY_N_OUT(YP_SUPPLY_N_OUT),
    .XP_SUPPLY_N_OUT(XP_SUPPLY_N_OUT), .XP_PULLUP_N_OUT(XP_PULLUP_N_OUT));
`default_nettype wire

// ### dv/adc_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_far_model (
    input wire logic clk_in, // bus clock
    input wire logic start_in, // start of conversion
    input wire logic [3:0] chan_in, // selected input
    input wire logic [11:0] level_in, // level to present
    input wire logic press_in, // stylus pressed
    output logic [11:0] data_out, // converted sample
    output logic stylus_out, // panel comparator
    output logic xtal_out // crystal clock
);
    // ----
    // analog side
    // ----
    // crystal runs free, phase unrelated to the bus clock
    initial xtal_out = 1'h0;
    always #85 xtal_out = ~xtal_out;
    assign stylus_out = press_in;
    // sample held from start; channel folded in so a wrong mux shows
    initial data_out = 12'h000;
    always @(posedge clk_in) begin
        if (start_in) begin
            data_out <= level_in ^ {8'h00, chan_in};
        end
    end
endmodule // adc_far_model
`default_nettype wire

// ### dv/adc_touch_control_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_touch_cfg.svh"
module adc_touch_control_regs_tb;
    // ----
    // signals
    // ----
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] chan_sel = 4'h0;
    logic [11:0] level = 12'h0;
    logic press = 1'h0;
    logic [31:0] prdata, rd, prev;
    logic [11:0] adc_data;
    logic [3:0] chan;
    logic pready, pslverr, err, stylus, xtal, cclk, cstart, cbusy, res12, stby;
    logic ymg, ypn, xmg, xpn, pun, cirq, tirq, r12;
    logic [8:0] v;
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'h3f76f03e;
    int cyc = 0;
    int n, i;
    realtime t0;
    localparam int TICKS = 5 * (5 + 1); // five ticks of divider value 5
    always #25 clk = ~clk;
    adc_touch_control_regs dut (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .ADC_DATA_IN(adc_data), .NORMAL_CHAN_IN(chan_sel), .STYLUS_DOWN_IN(stylus),
        .XTAL_IN(xtal), .CONV_CLK_OUT(cclk), .CONV_START_OUT(cstart), .CONV_BUSY_OUT(cbusy),
        .RES12_OUT(res12), .STANDBY_OUT(stby), .CHANNEL_OUT(chan), .YM_GROUND_OUT(ymg),
        .YP_SUPPLY_N_OUT(ypn), .XM_GROUND_OUT(xmg), .XP_SUPPLY_N_OUT(xpn), .XP_PULLUP_N_OUT(pun),
        .CONV_IRQ_OUT(cirq), .TOUCH_IRQ_OUT(tirq));
    adc_far_model far (.clk_in(clk), .start_in(cstart), .chan_in(chan), .level_in(level),
        .press_in(press), .data_out(adc_data), .stylus_out(stylus), .xtal_out(xtal));
    // ----
    // helpers
    // ----
    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one apb transfer; a spare edge after release avoids double drive
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1 && k < 16) begin
            @(posedge clk);
            k++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    task automatic waitp(input logic t, output int m);
        m = 0;
        while ((t ? tirq : cirq) !== 1'h1 && m < 3000) begin
            @(posedge clk);
            m++;
        end
    endtask
    function automatic logic [31:0] res_exp(input logic r, input logic [11:0] s);
        return r ? {20'h0, s} : {22'h0, s[11:2]};
    endfunction
    // software start with divider value 5, k conversions expected
    task automatic conv(input logic [8:0] tp, input int k);
        level <= 12'($random(seed));
        chan_sel <= 4'($random(seed));
        apb(1'h1, `OFS_TOUCH_CTRL, {23'h0, tp});
        apb(1'h1, `OFS_CONV_CTRL, {16'h0, 12'h414, r12, 3'h1});
        compare({30'h0, res12, stby}, {30'h0, r12, 1'h0});
        apb(1'h0, `OFS_CONV_CTRL, 32'h0);
        compare(rd & 32'h8001, 32'h0);
        waitp(1'h0, n);
        compare(32'(n >= k * (TICKS - 6) && n <= k * (TICKS + 14)), 32'h1);
        apb(1'h0, `OFS_CONV_CTRL, 32'h0);
        compare({31'h0, rd[15]}, 32'h1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        apb(1'h0, `OFS_CONV_CTRL, 32'h0);
        compare(rd, 32'h3fc4);
        apb(1'h0, `OFS_TOUCH_CTRL, 32'h0);
        compare(rd, 32'h58);
        apb(1'h0, `OFS_START_DELAY, 32'h0);
        compare(rd, 32'hff);
        apb(1'h0, 32'h58000020, 32'h0);
        compare({rd[31:1], err}, 32'h1);
        // pad switches follow the touch register
        repeat (6) begin
            v = 9'($random(seed)) & 9'h1f8;
            apb(1'h1, `OFS_TOUCH_CTRL, {23'h0, v});
            compare({27'h0, ymg, ypn, xmg, xpn, pun}, {27'h0, v[7:3]});
            apb(1'h0, `OFS_TOUCH_CTRL, 32'h0);
            compare(rd, {23'h0, v});
        end
        apb(1'h1, `OFS_START_DELAY, 32'h2);
        // normal, x, y, then auto sequence
        for (i = 0; i < 4; i++) begin
            r12 = 1'($random(seed));
            conv(i == 3 ? 9'h004 : 9'(i), i == 3 ? 2 : 1);
            apb(1'h0, `OFS_RESULT_FIRST, 32'h0);
            if (i != 2) compare(rd & 32'hfff, res_exp(r12, level ^ (i == 0 ? {8'h0, chan_sel} : 12'h7)));
            compare({29'h0, rd[14:12]}, {29'h0, i == 3, i == 3 ? 2'h0 : 2'(i)});
            apb(1'h0, `OFS_RESULT_SECOND, 32'h0);
            if (i > 1) compare(rd & 32'hfff, res_exp(r12, level ^ 12'h9));
            prev = rd;
        end
        apb(1'h1, `OFS_TOUCH_CTRL, 32'h0);
        apb(1'h1, `OFS_CONV_CTRL, 32'h4143);
        repeat (50) @(posedge clk);
        compare({31'h0, cbusy}, 32'h0);
        apb(1'h0, `OFS_RESULT_FIRST, 32'h0);
        waitp(1'h0, n);
        compare(32'(n < 3000), 32'h1);
        apb(1'h1, `OFS_CONV_CTRL, 32'h4145);
        repeat (50) @(posedge clk);
        compare({30'h0, cbusy, stby}, 32'h1);
        apb(1'h0, `OFS_RESULT_SECOND, 32'h0);
        compare(rd & 32'hfff, prev & 32'hfff);
        // divider off stalls the conversion, standby aborts it
        apb(1'h1, `OFS_CONV_CTRL, 32'h0141);
        repeat (60) @(posedge clk);
        compare({30'h0, cbusy, cclk}, 32'h2);
        apb(1'h1, `OFS_CONV_CTRL, 32'h0144);
        @(posedge clk);
        compare({31'h0, cbusy}, 32'h0);
        // stylus down, then up, debounced on the 170 ns crystal
        apb(1'h1, `OFS_START_DELAY, 32'h4);
        for (i = 0; i < 2; i++) begin
            apb(1'h1, `OFS_TOUCH_CTRL, i == 1 ? 32'h1d3 : 32'h0d3);
            press <= ~press;
            t0 = $realtime;
            waitp(1'h1, n);
            compare(32'(n < 3000 && $realtime - t0 >= 3 * 170.0), 32'h1);
            apb(1'h1, `OFS_TOUCH_CTRL, 32'h0);
        end
        summarize();
    end
endmodule // adc_touch_control_regs_tb
`default_nettype wire
